// *** cpl_pkg.sv ***
// shared constants of the channel protection latch block
package cpl_pkg;
  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int NCH     = 4;
  localparam int CNT_W   = 4;
  localparam int N_RETRY = 7;
  localparam int TMR_W   = 19;
  localparam int SYNC_W  = 6 * NCH + 3;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_KHZ       = 40_000;
  localparam int T_DELAY_MS    = 7;
  localparam int DELAY_CYCLES  = T_DELAY_MS * CLK_KHZ;

  // ****************************************************************
  // register map, byte addresses
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_CMD   = 8'h04;
  localparam logic [7:0] OFS_LATCH = 8'h08;
  localparam logic [7:0] OFS_ERR   = 8'h0C;
  localparam logic [7:0] OFS_STATE = 8'h10;

  // ****************************************************************
  // fields
  // ****************************************************************
  localparam int CTRL_OUT_LSB = 0;
  localparam int CTRL_LCM_LSB = 4;
  localparam int CMD_CLR_BIT  = 0;
  localparam int LAT_OC_LSB   = 0;
  localparam int LAT_OT_LSB   = 8;
  localparam int LAT_RT_LSB   = 16;
  localparam int ST_ON_LSB    = 0;
  localparam int ST_RED_LSB   = 8;
  localparam logic [31:0] RD_ZERO    = 32'h0000_0000;
  localparam logic [7:0]  CTRL_RESET = 8'h00;
endpackage : cpl_pkg

// *** cpl_sync.sv ***
// two flip-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module cpl_sync
  import cpl_pkg::*;
#(
  parameter int W = SYNC_W
)(
  input  wire logic         mclk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } cpl_sync_s;

  cpl_sync_s st_q;
  cpl_sync_s st_d;

  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign q = st_q.s2;
endmodule : cpl_sync
`default_nettype wire

// *** cpl_top.sv ***
// channel protection latch: per-channel fault sequencing with avalon-mm registers
// Functional notes
// - after delay, lower trip to reduced level
// - restart delay on shutdowns or input change
// - reduced trip exceeded: off and latch at once
// - latch clear command clears over-current latch
// - request still set: channel on after clear
// - over temperature switches off and latches
// - temp latch needs cooling plus clear command
// - dynamic trip off, auto restart while retries
// - too many restarts: off and retry latch
// - latch clear command clears retry latch
// - request rising edge resets restart counter while it is below the maximum
// - error flag set in dynamic shutdown, read clears
// - flag sets again if shutdown persists
// - during restart read clears, next trip sets
// - reverse polarity: all on, no protection
// - over voltage: outputs follow requests
// - ground lost: all channels off unless polarity is reversed
// - error flag also for over-current auto restart
//
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module cpl_top
  import cpl_pkg::*;
#(
  parameter int N         = NCH,
  parameter int DLY       = DELAY_CYCLES,
  parameter int NRETRY    = N_RETRY
)(
  input  wire logic         mclk,
  input  wire logic         rstn,
  input  wire logic [7:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  input  wire logic [3:0]   avs_byteenable,
  output logic      [31:0]  avs_readdata,
  output logic              avs_waitrequest,
  input  wire logic [N-1:0] in_pin,
  input  wire logic [N-1:0] oc_init_trip,
  input  wire logic [N-1:0] oc_reduced_trip,
  input  wire logic [N-1:0] over_temp,
  input  wire logic [N-1:0] temp_cooled,
  input  wire logic [N-1:0] dyn_temp_trip,
  input  wire logic         reverse_polarity,
  input  wire logic         ground_lost,
  input  wire logic         over_voltage,
  output logic      [N-1:0] chan_on,
  output logic      [N-1:0] reduced_trip_sel,
  output logic      [N-1:0] low_current_mode
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [N-1:0]             ctrl;
    logic [N-1:0]             lcm;
    logic [N-1:0]             oc;
    logic [N-1:0]             ot;
    logic [N-1:0]             rt;
    logic [N-1:0]             err;
    logic [N-1:0]             in_p;
    logic [N-1:0]             ctl_p;
    logic [N-1:0]             dyn_p;
    logic [N-1:0]             ocs_p;
    logic [N-1:0]             on;
    logic [N-1:0]             red;
    logic [N-1:0][TMR_W-1:0]  tmr;
    logic [N-1:0][CNT_W-1:0]  cnt;
    logic                     served;
    logic [31:0]              rdata;
  } cpl_s;

  cpl_s st_q;
  cpl_s st_d;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] syn;
  logic [N-1:0]      in_s;
  logic [N-1:0]      oci_s;
  logic [N-1:0]      ocr_s;
  logic [N-1:0]      ot_s;
  logic [N-1:0]      cool_s;
  logic [N-1:0]      dyn_s;
  logic              rev_s;
  logic              gnd_s;
  logic              ovv_s;

  assign raw = {over_voltage, ground_lost, reverse_polarity, dyn_temp_trip,
                temp_cooled, over_temp, oc_reduced_trip, oc_init_trip, in_pin};

  cpl_sync #(.W(SYNC_W)) u_sync (
    .mclk (mclk),
    .rstn (rstn),
    .d    (raw),
    .q    (syn)
  );

  assign in_s   = syn[N-1:0];
  assign oci_s  = syn[2*N-1:N];
  assign ocr_s  = syn[3*N-1:2*N];
  assign ot_s   = syn[4*N-1:3*N];
  assign cool_s = syn[5*N-1:4*N];
  assign dyn_s  = syn[6*N-1:5*N];
  assign rev_s  = syn[6*N];
  assign gnd_s  = syn[6*N+1];
  assign ovv_s  = syn[6*N+2];

  // ****************************************************************
  // avalon slave: one wait state, answer in the second cycle
  // ****************************************************************
  logic rd_ack;
  logic wr_ack;
  logic clr;

  function automatic logic [31:0] place(input logic [N-1:0] v, input int lsb);
    logic [31:0] r;
    r = RD_ZERO;
    r[lsb +: N] = v;
    return r;
  endfunction : place

  assign avs_waitrequest = (avs_read | avs_write) & ~st_q.served;
  assign rd_ack = avs_read & st_q.served;
  assign wr_ack = avs_write & st_q.served;
  // one command clears the over-current and retry latches of every channel, and the temp latches of cooled ones
  assign clr = wr_ack & (avs_address == OFS_CMD) & avs_byteenable[0]
             & avs_writedata[CMD_CLR_BIT];

  // ****************************************************************
  // next state
  // ****************************************************************
  logic [N-1:0] prot_v;
  logic [N-1:0] dyn_v;
  logic [N-1:0] ocs_v;
  logic [N-1:0] setoc_v;
  logic [N-1:0] re_v;
  logic [N-1:0] rise_v;
  logic [N-1:0] rst_v;
  logic [N-1:0] req_v;
  logic         err_rd;

  always_comb
  begin
    st_d   = st_q;
    err_rd = rd_ack & (avs_address == OFS_ERR);
    st_d.served = (avs_read | avs_write) & ~st_q.served;
    if (avs_read && !st_q.served)
    begin
      unique case (avs_address)
        OFS_CTRL:  st_d.rdata = place(st_q.ctrl, CTRL_OUT_LSB) | place(st_q.lcm, CTRL_LCM_LSB);
        OFS_LATCH: st_d.rdata = place(st_q.oc, LAT_OC_LSB) | place(st_q.ot, LAT_OT_LSB)
                              | place(st_q.rt, LAT_RT_LSB);
        OFS_ERR:   st_d.rdata = place(st_q.err, 0);
        OFS_STATE: st_d.rdata = place(st_q.on, ST_ON_LSB) | place(st_q.red, ST_RED_LSB);
        default:   st_d.rdata = RD_ZERO;
      endcase
    end
    if (wr_ack && avs_address == OFS_CTRL && avs_byteenable[0])
    begin
      st_d.ctrl = avs_writedata[CTRL_OUT_LSB +: N];
      st_d.lcm  = avs_writedata[CTRL_LCM_LSB +: N];
    end
    st_d.in_p  = in_s;
    st_d.ctl_p = st_q.ctrl;
    for (int i = 0; i < N; i++)
    begin
      // no protection acts while the supply is reversed
      prot_v[i]  = ~rev_s;
      req_v[i]   = in_s[i] | st_q.ctrl[i];
      dyn_v[i]   = dyn_s[i] & prot_v[i];
      ocs_v[i]   = oci_s[i] & ~st_q.red[i] & prot_v[i];
      setoc_v[i] = prot_v[i] & st_q.on[i] & st_q.red[i] & ocr_s[i];
      // a shutdown ended by a reversed supply is no restart to count
      re_v[i]    = ((st_q.dyn_p[i] & ~dyn_v[i]) | (st_q.ocs_p[i] & ~ocs_v[i]))
                 & prot_v[i];
      rise_v[i]  = (in_s[i] & ~st_q.in_p[i]) | (st_q.ctrl[i] & ~st_q.ctl_p[i]);
      rst_v[i]   = (dyn_v[i] & ~st_q.dyn_p[i]) | (ocs_v[i] & ~st_q.ocs_p[i]) | setoc_v[i]
                 | (in_s[i] ^ st_q.in_p[i]) | (st_q.ctrl[i] ^ st_q.ctl_p[i]);
      st_d.dyn_p[i] = dyn_v[i];
      st_d.ocs_p[i] = ocs_v[i];
      // set wins over the clear command in the same cycle
      st_d.oc[i] = setoc_v[i] | (st_q.oc[i] & ~clr);
      st_d.ot[i] = (prot_v[i] & ot_s[i]) | (st_q.ot[i] & ~(clr & cool_s[i]));
      st_d.rt[i] = (re_v[i] & (st_q.cnt[i] == CNT_W'(NRETRY)))
                 | (st_q.rt[i] & ~clr);
      if (clr)
        st_d.cnt[i] = '0;
      else if (rise_v[i] && st_q.cnt[i] < CNT_W'(NRETRY))
        st_d.cnt[i] = '0;
      else if (re_v[i] && st_q.cnt[i] < CNT_W'(NRETRY))
        st_d.cnt[i] = st_q.cnt[i] + CNT_W'(1);
      // only bits already reported by the read are cleared
      st_d.err[i] = dyn_v[i] | ocs_v[i]
                  | (st_q.err[i] & ~(err_rd & st_q.rdata[i]));
      if (rev_s)
        st_d.on[i] = 1'b1;
      else if (gnd_s)
        st_d.on[i] = 1'b0;
      else
        st_d.on[i] = req_v[i] & ~st_d.oc[i] & ~st_d.ot[i] & ~st_d.rt[i]
                   & ~dyn_v[i] & ~ocs_v[i];
      if (rst_v[i] || !st_q.on[i] || st_q.ot[i])
        st_d.tmr[i] = '0;
      else if (st_q.tmr[i] != TMR_W'(DLY))
        st_d.tmr[i] = st_q.tmr[i] + TMR_W'(1);
      st_d.red[i] = (st_d.tmr[i] == TMR_W'(DLY));
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q      <= '0;
      st_q.ctrl <= CTRL_RESET[N-1:0];
    end
    else
      st_q <= st_d;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign avs_readdata     = st_q.rdata;
  assign chan_on          = st_q.on;
  assign reduced_trip_sel = st_q.red;
  assign low_current_mode = st_q.lcm;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  gnd_off_a: assert property ((gnd_s && !rev_s) |=> chan_on == '0)
    else $error("channel on with ground lost");
  rev_on_a: assert property (rev_s |=> (chan_on == '1
                            && (st_q.oc & ~$past(st_q.oc)) == '0))
    else $error("reverse polarity not fully on");
  wait_one_a: assert property ((avs_read && !st_q.served) |-> avs_waitrequest ##1
                               !avs_waitrequest)
    else $error("bus answer not after one wait");

  // read data come from a register and stand until the next read
  rd_hold_a: assert property (!(avs_read && !st_q.served) |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  wr_wait_a: assert property ((avs_write && !st_q.served) |-> avs_waitrequest ##1
                              !avs_waitrequest)
    else $error("write answer not after one wait");

  // a write without byte lane zero must not touch the control bits
  ctrl_lane_a: assert property ((avs_write && !avs_byteenable[0]) |=> $stable(st_q.ctrl))
    else $error("control written without byte enable");
  lcm_wr_a: assert property ((wr_ack && avs_address == OFS_CTRL && avs_byteenable[0])
                             |=> low_current_mode == $past(avs_writedata[CTRL_LCM_LSB +: N]))
    else $error("low current mode bits not written");

  // a reversed supply must not leave any latch or flag behind
  rev_latch_a: assert property (rev_s |=> ((st_q.ot | st_q.rt)
                                & ~$past(st_q.ot | st_q.rt)) == '0)
    else $error("latch set with reversed supply");
  rev_err_a: assert property (rev_s |=> (st_q.err & ~$past(st_q.err)) == '0)
    else $error("error flag set with reversed supply");

  for (genvar g = 0; g < N; g++)
  begin : g_chk
    oc_trip_a: assert property ((st_q.on[g] && st_q.red[g] && ocr_s[g] && !rev_s)
                                |=> (st_q.oc[g] && !chan_on[g]))
      else $error("reduced trip did not latch");
    oc_clear_a: assert property ((clr && !setoc_v[g]
                                 && !(re_v[g] && st_q.cnt[g] == CNT_W'(NRETRY)))
                                |=> !st_q.oc[g] && !st_q.rt[g])
      else $error("clear left a latch set");
    ot_hold_a: assert property ((st_q.ot[g] && !(clr && cool_s[g])) |=> st_q.ot[g])
      else $error("temp latch released early");
    ot_set_a: assert property ((ot_s[g] && !rev_s) |=> (st_q.ot[g] && !chan_on[g]))
      else $error("over temperature not latched");
    tmr_rst_a: assert property (rst_v[g] |=> (st_q.tmr[g] == '0 && !st_q.red[g]))
      else $error("delay not restarted");
    red_seq_a: assert property ($rose(st_q.red[g]) |-> $past(st_q.on[g])
                                && !$past(st_q.ot[g]))
      else $error("trip lowered without activation");
    err_set_a: assert property ((dyn_s[g] && !rev_s) |=> st_q.err[g] && !chan_on[g])
      else $error("error flag missing in dynamic shutdown");
    rt_set_a: assert property ((re_v[g] && st_q.cnt[g] == CNT_W'(NRETRY))
                               |=> (st_q.rt[g] && !chan_on[g]))
      else $error("retry latch not set");
    cnt_rst_a: assert property ((rise_v[g] && st_q.cnt[g] < CNT_W'(NRETRY))
                                |=> st_q.cnt[g] == '0)
      else $error("restart counter not reset");
    follow_a: assert property ((!rev_s && !gnd_s && req_v[g] && st_d.oc[g] == 1'b0
                                && !st_d.ot[g] && !st_d.rt[g] && !dyn_v[g] && !ocs_v[g])
                               |=> chan_on[g])
      else $error("channel not following request");

    // latches hold until the clear command, and hold the channel off while the supply is not reversed
    oc_hold_a: assert property ((st_q.oc[g] && !clr) |=> st_q.oc[g])
      else $error("over-current latch lost");
    rt_hold_a: assert property ((st_q.rt[g] && !clr) |=> st_q.rt[g])
      else $error("retry latch lost");
    latch_off_a: assert property ((st_q.oc[g] || st_q.ot[g] || st_q.rt[g])
                                  && !clr && !rev_s |=> !chan_on[g])
      else $error("latched channel switched on");
    cnt_clr_a: assert property (clr |=> st_q.cnt[g] == '0)
      else $error("clear left a restart count");
    cnt_cap_a: assert property (st_q.cnt[g] <= CNT_W'(NRETRY))
      else $error("restart count above maximum");
    cnt_step_a: assert property ((re_v[g] && st_q.cnt[g] < CNT_W'(NRETRY) && !clr
                                 && !rise_v[g]) |=> st_q.cnt[g] == $past(st_q.cnt[g]) + CNT_W'(1))
      else $error("restart not counted");

    // the timer never runs past its end and only runs while on
    tmr_cap_a: assert property (st_q.tmr[g] <= TMR_W'(DLY))
      else $error("delay timer overran");
    red_off_a: assert property ((!st_q.on[g] || st_q.ot[g]) |=> !st_q.red[g])
      else $error("reduced trip without activation");

    // flags stay until a read reports them; shutdowns switch off
    err_keep_a: assert property ((st_q.err[g] && !(err_rd && st_q.rdata[g]))
                                 |=> st_q.err[g])
      else $error("error flag lost without read");
    err_clr_a: assert property ((err_rd && st_q.rdata[g] && !dyn_v[g] && !ocs_v[g])
                                |=> !st_q.err[g])
      else $error("error flag not cleared by read");
    dyn_off_a: assert property (dyn_v[g] |=> !chan_on[g])
      else $error("channel on in dynamic shutdown");
    ocs_off_a: assert property (ocs_v[g] |=> (!chan_on[g] && st_q.err[g]))
      else $error("over-current restart not flagged");
    no_req_a: assert property ((!rev_s && !req_v[g]) |=> !chan_on[g])
      else $error("channel on without request");
  end

  logic unused_ok;
  assign unused_ok = ovv_s;
endmodule : cpl_top
`default_nettype wire

// *** cpl_host.sv ***
// host model: avalon-mm master, channel input pins and latch clear pacing
`timescale 1ns/1ps
`default_nettype none
module cpl_host
  import cpl_pkg::*;
#(
  parameter int LRW = 8
)(
  input  wire logic           mclk,
  output logic      [7:0]     avs_address,
  output logic                avs_read,
  output logic                avs_write,
  output logic      [31:0]    avs_writedata,
  output logic      [3:0]     avs_byteenable,
  input  wire logic [31:0]    avs_readdata,
  input  wire logic           avs_waitrequest,
  output logic      [NCH-1:0] in_pin
);
  initial
  begin
    avs_address    = 8'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'hF;
    in_pin         = 4'h0;
  end

  // ****************************************************************
  // bus cycle: hold until waitrequest seen low, released lines invert
  // ****************************************************************
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge mclk);
    avs_read      <= !w;
    avs_write     <= w;
    avs_address   <= a;
    avs_writedata <= d;
    for (k = 0; k < 50; k++)
    begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    if (k == 50)
    begin
      tb.mismatches++;
      tb.test_done();
    end
    q = avs_readdata;
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    avs_address   <= ~a;
    avs_writedata <= ~d;
  endtask : acc

  task pin(input logic [NCH-1:0] v);
    @(posedge mclk);
    in_pin <= v;
  endtask : pin

  // pacing only protects the part; the block itself does not enforce it
  task clr;
    logic [31:0] q;
    repeat (LRW) @(posedge mclk);
    acc(1'b1, OFS_CMD, 32'h0000_0001, q);
  endtask : clr
endmodule : cpl_host
`default_nettype wire

// *** tb.sv ***
// self-checking bench of the channel protection latch
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cpl_pkg::*;
  localparam int DLY = 20;
  logic        mclk;
  logic        rstn;
  logic [7:0]  adr;
  logic        rd;
  logic        wr;
  logic [31:0] wd;
  logic [3:0]  be;
  logic [31:0] rdat;
  logic        wrq;
  logic [3:0]  pin;
  logic [3:0]  oci;
  logic [3:0]  ocr;
  logic [3:0]  ot;
  logic [3:0]  cool;
  logic [3:0]  dyn;
  logic        rev;
  logic        gnd;
  logic        ov;
  logic [3:0]  chan_on;
  logic [3:0]  red;
  logic [3:0]  lcm;
  int          mismatches = 0;
  int          n_tests = 0;

  cpl_host host_i (.mclk(mclk), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wrq),
    .in_pin(pin));
  cpl_top #(.DLY(DLY), .NRETRY(2)) cpl_top_i (.mclk(mclk), .rstn(rstn), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(rdat), .avs_waitrequest(wrq), .in_pin(pin), .oc_init_trip(oci),
    .oc_reduced_trip(ocr), .over_temp(ot), .temp_cooled(cool), .dyn_temp_trip(dyn),
    .reverse_polarity(rev), .ground_lost(gnd), .over_voltage(ov), .chan_on(chan_on),
    .reduced_trip_sel(red), .low_current_mode(lcm));

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task w(input int n);
    repeat (n) @(negedge mclk);
  endtask : w

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    host_i.acc(1'b0, a, 32'h0000_0000, q);
    chk("readdata", e, q);
  endtask : rc

  task test_done;
    if (mismatches == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  // restart path of channel 2; the read while tripped proves re-set
  task dp(input int n);
    repeat (n)
    begin
      @(posedge mclk) dyn <= 4'h4;
      w(4);
      chk("chan_on", 4'h3, chan_on);
      rc(OFS_ERR, 32'h0000_0004);
      rc(OFS_ERR, 32'h0000_0004);
      @(posedge mclk) dyn <= 4'h0;
      w(4);
      chk("chan_on", 4'h7, chan_on);
      rc(OFS_ERR, 32'h0000_0004);
      rc(OFS_ERR, 32'h0000_0000);
    end
  endtask : dp

  initial
  begin
    logic [31:0] q;
    rstn <= 1'b0;
    {oci, ocr, ot, cool, dyn} <= 20'h0_0000;
    {rev, gnd, ov} <= 3'h0;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    w(1);
    chk("chan_on", 4'h0, chan_on);
    rc(OFS_CTRL, 32'h0000_0000);
    rc(8'h14, 32'h0000_0000);
    host_i.acc(1'b1, OFS_CTRL, 32'h0000_00F0, q);
    w(4);
    chk("low_current_mode", 4'hF, lcm);
    host_i.pin(4'h1);
    w(5);
    chk("reduced_trip_sel", 4'h0, red);
    w(DLY);
    chk("reduced_trip_sel", 4'h1, red);
    host_i.acc(1'b1, OFS_CTRL, 32'h0000_00F1, q);
    w(3);
    chk("reduced_trip_sel", 4'h0, red);
    w(DLY + 5);
    @(posedge mclk) ocr <= 4'h1;
    w(4);
    chk("chan_on", 4'h0, chan_on);
    @(posedge mclk) ocr <= 4'h0;
    w(5);
    chk("chan_on", 4'h0, chan_on);
    rc(OFS_LATCH, 32'h0000_0001);
    host_i.clr();
    w(4);
    chk("chan_on", 4'h1, chan_on);
    rc(OFS_LATCH, 32'h0000_0000);
    host_i.pin(4'h3);
    @(posedge mclk) ot <= 4'h2;
    w(5);
    chk("chan_on", 4'h1, chan_on);
    rc(OFS_LATCH, 32'h0000_0200);
    @(posedge mclk) ot <= 4'h0;
    host_i.clr();
    w(4);
    chk("chan_on", 4'h1, chan_on);
    @(posedge mclk) cool <= 4'h2;
    host_i.clr();
    w(4);
    chk("chan_on", 4'h3, chan_on);
    host_i.pin(4'h7);
    w(5);
    dp(1);
    host_i.pin(4'h3);
    host_i.pin(4'h7);
    w(5);
    dp(2);
    @(posedge mclk) dyn <= 4'h4;
    w(4);
    @(posedge mclk) dyn <= 4'h0;
    w(4);
    chk("chan_on", 4'h3, chan_on);
    rc(OFS_LATCH, 32'h0004_0000);
    host_i.clr();
    w(4);
    chk("chan_on", 4'h7, chan_on);
    rc(OFS_LATCH, 32'h0000_0000);
    host_i.pin(4'hF);
    w(5);
    @(posedge mclk) oci <= 4'h8;
    w(4);
    chk("chan_on", 4'h7, chan_on);
    rc(OFS_ERR, 32'h0000_000C);
    @(posedge mclk) oci <= 4'h0;
    w(4);
    chk("chan_on", 4'hF, chan_on);
    host_i.pin(4'h0);
    @(posedge mclk) rev <= 1'b1;
    ot <= 4'hF;
    w(5);
    chk("chan_on", 4'hF, chan_on);
    @(posedge mclk) ot <= 4'h0;
    w(4);
    @(posedge mclk) rev <= 1'b0;
    w(5);
    rc(OFS_LATCH, 32'h0000_0000);
    @(posedge mclk) ov <= 1'b1;
    host_i.pin(4'h6);
    w(5);
    chk("chan_on", 4'h7, chan_on);
    @(posedge mclk) gnd <= 1'b1;
    w(5);
    chk("chan_on", 4'h0, chan_on);
    test_done();
  end
endmodule : tb
`default_nettype wire
